// File: common/pattern_defs.vh
// Purpose: constants of the timed pattern output register block
// Assumes: haddr bits 17:2 carry the register index, byte address is four times it
// Notes: every register is one aligned word, data in bits 7:0
`ifndef PATTERN_DEFS_VH
`define PATTERN_DEFS_VH
// ----------------------------------------------------------------
// register indices; byte address is four times the index, so one index step is one word
// ----------------------------------------------------------------
`define ADDR_NEXT_HIGH 16'hffa4
`define ADDR_NEXT_LOW 16'hffa5
`define ADDR_NEXT_G2_ALT 16'hffa6
`define ADDR_NEXT_G0_ALT 16'hffa7
`define ADDR_PORT_A_DIR 16'hffd1
`define ADDR_PORT_A_DATA 16'hffd3
`define ADDR_PORT_B_DIR 16'hffd4
`define ADDR_PORT_B_DATA 16'hffd6
`define ADDR_MODE 16'hffa0
`define ADDR_TRIG_SEL 16'hffa1
`define ADDR_HIGH_EN 16'hffa2
`define ADDR_LOW_EN 16'hffa3
`define IDX_MSB 17
`define IDX_LSB 2
`define RST_IDX 16'h0000
// ----------------------------------------------------------------
// reset values and fields
// ----------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_TRIG_SEL 8'hff
`define RST_MODE 8'hf0
`define ONES_NIB 4'hf
`define BIT_FOURTEEN 6
`define HTRANS_NONSEQ 2'b10
`define HRESP_OKAY 1'b0
`endif

// File: rtl/group_trigger.v
// Purpose: pick one compare-match strobe for a group
// Assumes: strobes are one cycle wide
// Notes: purely combinational
`timescale 1ns/100ps
module group_trigger (
  input wire [3:0] match_strobe,
  input wire [1:0] select,
  output wire fire
);
  assign fire = match_strobe[select];
endmodule // group_trigger

// File: rtl/pattern_byte.v
// Purpose: one 8-bit port data register with pattern transfer
// Assumes: fire_lo/fire_hi are one-cycle strobes
// Notes: hardware copy wins over software write per bit
`timescale 1ns/100ps
`include "pattern_defs.vh"
module pattern_byte (
  input wire hclk,
  input wire hresetn,
  input wire wr,
  input wire [7:0] wdata,
  input wire [7:0] enable,
  input wire [7:0] next_data,
  input wire fire_lo,
  input wire fire_hi,
  output reg [7:0] data_reg
);
  reg [7:0] data_next;
  wire [7:0] fire_mask;
  assign fire_mask = {{4{fire_hi}}, {4{fire_lo}}} & enable;
  always @*
  begin
    data_next = data_reg;
    if (wr)
    begin
      data_next = (data_reg & enable) | (wdata & ~enable);
    end
    data_next = (data_next & ~fire_mask) | (next_data & fire_mask);
  end
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      data_reg <= `RST_BYTE;
    end
    else
    begin
      data_reg <= data_next;
    end
  end
endmodule // pattern_byte

// File: rtl/pattern_output_unit.v
// Purpose: register file and transfer logic of the pattern output unit
// Assumes: ahb-lite single word transfers, one slave; standby reset on hw_standby
// Notes: reads take one wait state; unmapped indices read zero, writes dropped
`timescale 1ns/100ps
`include "pattern_defs.vh"
module pattern_output_unit (
  input wire hclk,
  input wire hresetn,
  input wire hw_standby,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire [3:0] match_strobe,
  output reg [7:0] port_a_pins,
  output reg [7:0] port_a_pins_oe,
  output reg [7:0] port_b_pins,
  output reg [7:0] port_b_pins_oe
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // standby acts as a second reset; it is a level, so applied synchronously
  reg [7:0] port_a_direction_reg;
  reg [7:0] port_b_direction_reg;
  reg [7:0] next_data_low_groups_reg;
  reg [7:0] next_data_high_groups_reg;
  reg [7:0] low_groups_output_enable_reg;
  reg [7:0] high_groups_output_enable_reg;
  reg [7:0] trigger_select_register_reg;
  reg [7:0] overlap_mode_register_reg;
  wire [7:0] port_a_output_data;
  wire [7:0] port_b_output_data;
  localparam BUS_IDLE = 2'b00;
  localparam BUS_WRITE = 2'b01;
  localparam BUS_READ = 2'b10;
  reg [1:0] bus_state_reg;
  reg [1:0] bus_state_next;
  reg [15:0] addr_reg;
  wire [15:0] bus_idx;
  wire take;
  wire wr_now;
  wire rd_now;
  wire low_shared;
  wire high_shared;
  wire [3:0] fire;
  reg [7:0] rd_byte;

  function hit;
    input [15:0] a;
    input [15:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  function [7:0] nib_write;
    input [7:0] old;
    input [7:0] wd;
    input hi_en;
    input lo_en;
    begin
      nib_write = {hi_en ? wd[7:4] : old[7:4], lo_en ? wd[3:0] : old[3:0]};
    end
  endfunction

  function [1:0] start_state;
    input t;
    input w;
    begin
      start_state = BUS_IDLE;
      if (t)
      begin
        start_state = w ? BUS_WRITE : BUS_READ;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // bus front end
  // ----------------------------------------------------------------
  // reads wait one cycle so a write still in its data phase
  // has landed before the read value is picked
  assign bus_idx = haddr[`IDX_MSB:`IDX_LSB];
  assign take = hsel && hready && (htrans == `HTRANS_NONSEQ);
  assign wr_now = (bus_state_reg == BUS_WRITE);
  assign rd_now = (bus_state_reg == BUS_READ);

  always @*
  begin
    bus_state_next = BUS_IDLE;
    case (bus_state_reg)
      BUS_IDLE:
      begin
        bus_state_next = start_state(take, hwrite);
      end
      BUS_WRITE:
      begin
        bus_state_next = start_state(take, hwrite);
      end
      BUS_READ:
      begin
        bus_state_next = BUS_IDLE;
      end
      default:
      begin
        bus_state_next = BUS_IDLE;
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus_state_reg <= BUS_IDLE;
      addr_reg <= `RST_IDX;
      hreadyout <= 1'b1;
      hresp <= `HRESP_OKAY;
    end
    else
    begin
      bus_state_reg <= bus_state_next;
      if (take)
      begin
        addr_reg <= bus_idx;
      end
      hreadyout <= (bus_state_next != BUS_READ);
      hresp <= `HRESP_OKAY;
    end
  end

  assign low_shared = trigger_select_register_reg[1:0] == trigger_select_register_reg[3:2];
  assign high_shared = trigger_select_register_reg[5:4] == trigger_select_register_reg[7:6];

  // ----------------------------------------------------------------
  // read mux, data registered for the data phase
  // ----------------------------------------------------------------
  always @*
  begin
    rd_byte = 8'h00;
    if (hit(addr_reg, `ADDR_NEXT_LOW))
    begin
      rd_byte = low_shared ? next_data_low_groups_reg :
        {next_data_low_groups_reg[7:4], `ONES_NIB};
    end
    else if (hit(addr_reg, `ADDR_NEXT_G0_ALT))
    begin
      rd_byte = low_shared ? 8'hff : {`ONES_NIB, next_data_low_groups_reg[3:0]};
    end
    else if (hit(addr_reg, `ADDR_NEXT_HIGH))
    begin
      rd_byte = high_shared ? next_data_high_groups_reg :
        {next_data_high_groups_reg[7:4], `ONES_NIB};
    end
    else if (hit(addr_reg, `ADDR_NEXT_G2_ALT))
    begin
      rd_byte = high_shared ? 8'hff : {`ONES_NIB, next_data_high_groups_reg[3:0]};
    end
    else if (hit(addr_reg, `ADDR_PORT_A_DATA))
    begin
      rd_byte = port_a_output_data;
    end
    else if (hit(addr_reg, `ADDR_PORT_B_DATA))
    begin
      rd_byte = port_b_output_data;
    end
    else if (hit(addr_reg, `ADDR_LOW_EN))
    begin
      rd_byte = low_groups_output_enable_reg;
    end
    else if (hit(addr_reg, `ADDR_HIGH_EN))
    begin
      rd_byte = high_groups_output_enable_reg;
    end
    else if (hit(addr_reg, `ADDR_TRIG_SEL))
    begin
      rd_byte = trigger_select_register_reg;
    end
    else if (hit(addr_reg, `ADDR_MODE))
    begin
      rd_byte = overlap_mode_register_reg;
    end
    // direction registers are write-only and read zero
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h00000000;
    end
    else if (rd_now)
    begin
      hrdata <= {24'h000000, rd_byte};
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      port_a_direction_reg <= `RST_BYTE;
      port_b_direction_reg <= `RST_BYTE;
      low_groups_output_enable_reg <= `RST_BYTE;
      high_groups_output_enable_reg <= `RST_BYTE;
      trigger_select_register_reg <= `RST_TRIG_SEL;
      overlap_mode_register_reg <= `RST_MODE;
    end
    else if (hw_standby)
    begin
      port_a_direction_reg <= `RST_BYTE;
      port_b_direction_reg <= `RST_BYTE;
      low_groups_output_enable_reg <= `RST_BYTE;
      high_groups_output_enable_reg <= `RST_BYTE;
      trigger_select_register_reg <= `RST_TRIG_SEL;
      overlap_mode_register_reg <= `RST_MODE;
    end
    else if (wr_now)
    begin
      if (hit(addr_reg, `ADDR_PORT_A_DIR))
      begin
        port_a_direction_reg <= hwdata[7:0];
      end
      if (hit(addr_reg, `ADDR_PORT_B_DIR))
      begin
        port_b_direction_reg <= hwdata[7:0];
      end
      if (hit(addr_reg, `ADDR_LOW_EN))
      begin
        low_groups_output_enable_reg <= hwdata[7:0];
      end
      if (hit(addr_reg, `ADDR_HIGH_EN))
      begin
        high_groups_output_enable_reg <= hwdata[7:0];
      end
      if (hit(addr_reg, `ADDR_TRIG_SEL))
      begin
        trigger_select_register_reg <= hwdata[7:0];
      end
      if (hit(addr_reg, `ADDR_MODE))
      begin
        overlap_mode_register_reg <= hwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // next data registers with address remap
  // ----------------------------------------------------------------
  // sharing is judged at the data phase, with the select value in force then
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      next_data_low_groups_reg <= `RST_BYTE;
      next_data_high_groups_reg <= `RST_BYTE;
    end
    else if (hw_standby)
    begin
      next_data_low_groups_reg <= `RST_BYTE;
      next_data_high_groups_reg <= `RST_BYTE;
    end
    else if (wr_now)
    begin
      if (hit(addr_reg, `ADDR_NEXT_LOW))
      begin
        next_data_low_groups_reg <= nib_write(next_data_low_groups_reg, hwdata[7:0], 1'b1, low_shared);
      end
      else if (hit(addr_reg, `ADDR_NEXT_G0_ALT))
      begin
        next_data_low_groups_reg <= nib_write(next_data_low_groups_reg, hwdata[7:0], 1'b0, !low_shared);
      end
      else if (hit(addr_reg, `ADDR_NEXT_HIGH))
      begin
        next_data_high_groups_reg <= nib_write(next_data_high_groups_reg, hwdata[7:0], 1'b1, high_shared);
      end
      else if (hit(addr_reg, `ADDR_NEXT_G2_ALT))
      begin
        next_data_high_groups_reg <= nib_write(next_data_high_groups_reg, hwdata[7:0], 1'b0, !high_shared);
      end
    end
  end

  // ----------------------------------------------------------------
  // trigger selection per group
  // ----------------------------------------------------------------
  group_trigger u_trig0 (.match_strobe(match_strobe), .select(trigger_select_register_reg[1:0]), .fire(fire[0]));
  group_trigger u_trig1 (.match_strobe(match_strobe), .select(trigger_select_register_reg[3:2]), .fire(fire[1]));
  group_trigger u_trig2 (.match_strobe(match_strobe), .select(trigger_select_register_reg[5:4]), .fire(fire[2]));
  group_trigger u_trig3 (.match_strobe(match_strobe), .select(trigger_select_register_reg[7:6]), .fire(fire[3]));

  // ----------------------------------------------------------------
  // port data registers
  // ----------------------------------------------------------------
  pattern_byte u_port_a (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr(wr_now && hit(addr_reg, `ADDR_PORT_A_DATA)),
    .wdata(hwdata[7:0]),
    .enable(low_groups_output_enable_reg),
    .next_data(next_data_low_groups_reg),
    .fire_lo(fire[0]),
    .fire_hi(fire[1]),
    .data_reg(port_a_output_data)
  );

  pattern_byte u_port_b (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr(wr_now && hit(addr_reg, `ADDR_PORT_B_DATA)),
    .wdata(hwdata[7:0]),
    .enable(high_groups_output_enable_reg),
    .next_data(next_data_high_groups_reg),
    .fire_lo(fire[2]),
    .fire_hi(fire[3]),
    .data_reg(port_b_output_data)
  );

  // ----------------------------------------------------------------
  // pin drivers, registered; one cycle behind the data registers
  // ----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      port_a_pins <= `RST_BYTE;
      port_a_pins_oe <= `RST_BYTE;
      port_b_pins <= `RST_BYTE;
      port_b_pins_oe <= `RST_BYTE;
    end
    else
    begin
      port_a_pins <= port_a_output_data;
      port_a_pins_oe <= port_a_direction_reg;
      port_b_pins <= port_b_output_data;
      port_b_pins_oe <= port_b_direction_reg;
      port_b_pins[`BIT_FOURTEEN] <= 1'b0;
      port_b_pins_oe[`BIT_FOURTEEN] <= 1'b0;
    end
  end
endmodule // pattern_output_unit

// File: test/pattern_monitor.sv
// Purpose: port-level checks of the pattern output unit
// Assumes: one clock, async active-low reset
// Notes: pin changes must trace back to a write, a strobe or standby
`timescale 1ns/100ps
`include "pattern_defs.vh"
module pattern_monitor (
  input wire hclk,
  input wire hresetn,
  input wire hw_standby,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire [3:0] match_strobe,
  input wire [7:0] port_a_pins,
  input wire [7:0] port_a_pins_oe,
  input wire [7:0] port_b_pins,
  input wire [7:0] port_b_pins_oe
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------------------------------------------------------
  // cause history
  // ----------------------------------------------------------------
  wire take = hsel && hready && (htrans == `HTRANS_NONSEQ);
  wire [15:0] idx = haddr[`IDX_MSB:`IDX_LSB];
  wire rd_dir = take && !hwrite && (idx == `ADDR_PORT_A_DIR || idx == `ADDR_PORT_B_DIR);
  // three deep: write lands one edge late, pins one more
  reg [2:0] wr_hist;
  reg [2:0] st_hist;
  reg [2:0] sb_hist;
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_hist <= 3'h0;
      st_hist <= 3'h0;
      sb_hist <= 3'h0;
    end
    else
    begin
      wr_hist <= {wr_hist[1:0], take && hwrite};
      st_hist <= {st_hist[1:0], |match_strobe};
      sb_hist <= {sb_hist[1:0], hw_standby};
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_DIR_RD_ZERO: assert property (rd_dir |-> ##2 hrdata == 32'h00000000)
    else $error("direction register read back nonzero");
  AST_OE_RESET: assert property ($rose(hresetn) |-> port_a_pins_oe == 8'h00 && port_b_pins_oe == 8'h00)
    else $error("pin enables not clear after reset");
  AST_STBY_OE: assert property (hw_standby ##1 hw_standby |=> port_a_pins_oe == 8'h00 && port_b_pins_oe == 8'h00)
    else $error("standby left pin enables set");
  AST_A_OE_CAUSE: assert property ($changed(port_a_pins_oe) |-> (|wr_hist) || (|sb_hist))
    else $error("port a enables changed without a write");
  AST_B_OE_CAUSE: assert property ($changed(port_b_pins_oe) |-> (|wr_hist) || (|sb_hist))
    else $error("port b enables changed without a write");
  AST_A_PIN_CAUSE: assert property ($changed(port_a_pins) |-> (|wr_hist) || (|st_hist))
    else $error("port a pins changed without write or strobe");
  AST_B_PIN_CAUSE: assert property ($changed(port_b_pins) |-> (|wr_hist) || (|st_hist))
    else $error("port b pins changed without write or strobe");
  AST_PIN14: assert property (port_b_pins[6] == 1'b0 && port_b_pins_oe[6] == 1'b0)
    else $error("output fourteen reached a pin");
endmodule // pattern_monitor
bind pattern_output_unit pattern_monitor mon (.hclk(hclk), .hresetn(hresetn), .hw_standby(hw_standby),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .match_strobe(match_strobe),
  .port_a_pins(port_a_pins), .port_a_pins_oe(port_a_pins_oe), .port_b_pins(port_b_pins),
  .port_b_pins_oe(port_b_pins_oe));

// File: test/timer_model.sv
// Purpose: compare-match strobe source standing in for the timer
// Assumes: bench raises fire_req for one or more cycles
// Notes: a held request still gives a single strobe
`timescale 1ns/100ps
module timer_model (
  input wire hclk,
  input wire hresetn,
  input wire [3:0] fire_req,
  output reg [3:0] match_strobe
);
  reg [3:0] req_d;
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      req_d <= 4'h0;
      match_strobe <= 4'h0;
    end
    else
    begin
      req_d <= fire_req;
      match_strobe <= fire_req & ~req_d;
    end
  end
endmodule // timer_model

// File: test/tb.sv
// Purpose: register and transfer tests of the pattern output unit
// Assumes: slave may insert wait states, strobes from timer_model
// Notes: expected values follow the nibble remapping by hand
`timescale 1ns/100ps
`include "pattern_defs.vh"
module tb;
  reg hclk = 1'b0;
  reg hresetn = 1'b0;
  reg hw_standby = 1'b0;
  reg hsel = 1'b0;
  reg hwrite = 1'b0;
  reg [31:0] haddr = 32'h0;
  reg [31:0] hwdata = 32'h0;
  reg [1:0] htrans = 2'b00;
  reg [2:0] hsize = 3'h2;
  reg [3:0] fire_req = 4'h0;
  wire [31:0] hrdata;
  wire hreadyout;
  wire hresp;
  wire [3:0] match_strobe;
  wire [7:0] pa;
  wire [7:0] pa_oe;
  wire [7:0] pb;
  wire [7:0] pb_oe;
  integer error_cnt = 0;
  integer comparisons = 0;
  always #4 hclk = ~hclk;
  timer_model tmr (.hclk(hclk), .hresetn(hresetn), .fire_req(fire_req), .match_strobe(match_strobe));
  pattern_output_unit uut (.hclk(hclk), .hresetn(hresetn), .hw_standby(hw_standby), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .match_strobe(match_strobe),
    .port_a_pins(pa), .port_a_pins_oe(pa_oe), .port_b_pins(pb), .port_b_pins_oe(pb_oe));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task finish_test;
    begin
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp)
      begin
        $display("ERROR at %0t got %h expected %h", $time, got, exp);
        error_cnt = error_cnt + 1;
      end
    end
  endtask
  // bounded wait for hready high at a rising edge
  task wait_rdy;
    integer n;
    begin
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
      begin
        n = n + 1;
        if (n > 16)
        begin
          error_cnt = error_cnt + 1;
          finish_test;
        end
        @(posedge hclk);
      end
    end
  endtask
  task xfer(input [15:0] a, input w, input [7:0] d);
    begin
      hsel <= 1'b1;
      htrans <= `HTRANS_NONSEQ;
      hwrite <= w;
      haddr <= {14'h0000, a, 2'b00};
      wait_rdy;
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h000000, d};
      wait_rdy;
    end
  endtask
  task wr(input [15:0] a, input [7:0] d);
    xfer(a, 1'b1, d);
  endtask
  task rd(input [15:0] a, input [31:0] e);
    begin
      xfer(a, 1'b0, 8'h00);
      chk(hrdata, e);
      chk({31'h0, hresp}, {31'h0, `HRESP_OKAY});
    end
  endtask
  task pulse(input [3:0] m);
    begin
      fire_req <= m;
      @(posedge hclk);
      fire_req <= 4'h0;
      repeat (3) @(posedge hclk);
    end
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`ADDR_LOW_EN, 32'h00);
    rd(`ADDR_TRIG_SEL, 32'hff);
    rd(`ADDR_NEXT_LOW, 32'h00);
    rd(`ADDR_NEXT_HIGH, 32'h00);
    rd(`ADDR_PORT_A_DIR, 32'h00);
    rd(16'hfff0, 32'h00);
    wr(`ADDR_NEXT_LOW, 8'ha5);
    wr(`ADDR_NEXT_G0_ALT, 8'h00);
    rd(`ADDR_NEXT_LOW, 32'ha5);
    rd(`ADDR_NEXT_G0_ALT, 32'hff);
    wr(`ADDR_NEXT_HIGH, 8'h96);
    wr(`ADDR_NEXT_G2_ALT, 8'h00);
    rd(`ADDR_NEXT_HIGH, 32'h96);
    rd(`ADDR_NEXT_G2_ALT, 32'hff);
    // groups 0 and 2 on channel 0, groups 1 and 3 on channel 3
    wr(`ADDR_TRIG_SEL, 8'hcc);
    rd(`ADDR_TRIG_SEL, 32'hcc);
    rd(`ADDR_NEXT_LOW, 32'haf);
    rd(`ADDR_NEXT_G0_ALT, 32'hf5);
    wr(`ADDR_NEXT_G0_ALT, 8'h3c);
    rd(`ADDR_NEXT_G0_ALT, 32'hfc);
    rd(`ADDR_NEXT_HIGH, 32'h9f);
    rd(`ADDR_NEXT_G2_ALT, 32'hf6);
    wr(`ADDR_NEXT_HIGH, 8'hf0);
    wr(`ADDR_PORT_A_DIR, 8'hff);
    wr(`ADDR_PORT_B_DIR, 8'hff);
    wr(`ADDR_LOW_EN, 8'h0f);
    rd(`ADDR_LOW_EN, 32'h0f);
    wr(`ADDR_HIGH_EN, 8'hf0);
    rd(`ADDR_HIGH_EN, 32'hf0);
    pulse(4'h8);
    rd(`ADDR_PORT_A_DATA, 32'h00);
    rd(`ADDR_PORT_B_DATA, 32'hf0);
    pulse(4'h1);
    rd(`ADDR_PORT_A_DATA, 32'h0c);
    rd(`ADDR_PORT_B_DATA, 32'hf0);
    wr(`ADDR_PORT_A_DATA, 8'hff);
    rd(`ADDR_PORT_A_DATA, 32'hfc);
    wr(`ADDR_PORT_B_DATA, 8'h05);
    rd(`ADDR_PORT_B_DATA, 32'hf5);
    chk({24'h0, pa}, 32'hfc);
    chk({24'h0, pa_oe}, 32'hff);
    chk({24'h0, pb}, 32'hb5);
    chk({24'h0, pb_oe}, 32'hbf);
    // standby reloads the reset values of the registers but not the port data
    hw_standby <= 1'b1;
    repeat (2) @(posedge hclk);
    hw_standby <= 1'b0;
    @(posedge hclk);
    rd(`ADDR_LOW_EN, 32'h00);
    rd(`ADDR_NEXT_LOW, 32'h00);
    rd(`ADDR_NEXT_HIGH, 32'h00);
    rd(`ADDR_TRIG_SEL, 32'hff);
    rd(`ADDR_HIGH_EN, 32'h00);
    chk({24'h0, pa_oe}, 32'h00);
    finish_test;
  end
endmodule // tb
